// *** sim/adc_output_format_and_range_flags_tb.sv ***
// Self-checking bench for the converter output stage.
// Assumes the design package and the capture model are compiled first.
module adc_output_format_and_range_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_fmt_pkg::*;
    // ==========================================================
    // Stimulus, design and far side
    logic clk = 1'b0, sys_rst = 1'b1, sample_en = 1'b0, raw_below = 1'b0, raw_above = 1'b0;
    logic msb_invert_pin = 1'b0, low_bits_invert_pin = 1'b0, pattern_sel_n = 1'b1;
    logic float_pin = 1'b0, sleep_request_pin = 1'b0;
    logic [RES_W-1:0] raw_code = '0, result_bits, last_word, m, ew, ew_prev;
    logic result_oe, over_range_flag, under_range_flag, flags_oe, asleep, accuracy_ok, got;
    logic [11:0] e, q[$];
    int fail_count = 0, cmp_count = 0, kept, seed, k0, n_out = 0;
    always #5 clk = ~clk;
    adc_output_format dut (.clk(clk), .sys_rst(sys_rst), .sample_en(sample_en),
        .raw_code(raw_code), .raw_below(raw_below), .raw_above(raw_above),
        .msb_invert_pin(msb_invert_pin), .low_bits_invert_pin(low_bits_invert_pin),
        .pattern_sel_n(pattern_sel_n), .float_pin(float_pin),
        .sleep_request_pin(sleep_request_pin), .result_bits(result_bits),
        .result_oe(result_oe), .over_range_flag(over_range_flag),
        .under_range_flag(under_range_flag), .flags_oe(flags_oe), .asleep(asleep),
        .accuracy_ok(accuracy_ok));
    capture_model far_end (.clk(clk), .sample_en(sample_en), .result_bits(result_bits),
        .result_oe(result_oe), .accuracy_ok(accuracy_ok), .last_word(last_word), .kept(kept));
    // ==========================================================
    // Compare tasks and verdict
    task cmp_word(input string n, input logic [RES_W-1:0] x, input logic [RES_W-1:0] g);
        cmp_count++;
        if (g !== x)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task cmp_bit(input string n, input logic x, input logic g);
        cmp_word(n, {9'h000, x}, {9'h000, g});
    endtask
    task results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Random samples, one third of cycles idle, some out of range
    task drive(input int n);
        int r;
        repeat (n)
        begin
            @(posedge clk);
            r = $urandom % 8;
            sample_en <= ($urandom % 3) != 0;
            raw_below <= r == 0;
            raw_above <= r == 1;
            raw_code <= (r == 0) ? ZERO_CODE : (r == 1) ? 10'h3ff : 10'($urandom);
        end
    endtask
    // ==========================================================
    // Reference pipeline: output at a pulse is the input three pulses back
    always @(posedge clk)
    begin
        if (!sys_rst && sample_en)
        begin
            q.push_back({raw_below, raw_above, raw_code});
            if (q.size() == 4)
            begin
                e = q.pop_front();
                // Far side takes the word standing before this edge
                got = result_oe && accuracy_ok && n_out > 0;
                m = (msb_invert_pin ? MSB_MASK : ZERO_CODE) |
                    (low_bits_invert_pin ? LOW_MASK : ZERO_CODE);
                ew = (pattern_sel_n ? e[9:0] : TEST_PATTERN) ^ m;
                #1;
                cmp_word("result_bits", ew, result_bits);
                cmp_bit("under_range_flag", e[11], under_range_flag);
                cmp_bit("over_range_flag", e[10], over_range_flag);
                if (got)
                    cmp_word("capture last_word", ew_prev, last_word);
                ew_prev = ew;
                n_out++;
            end
        end
    end
    // Watchdog
    initial
    begin
        #50000;
        fail_count++;
        results();
    end
    // ==========================================================
    // Tests
    initial
    begin
        seed = $urandom(32'h6bb5);
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        cmp_word("reset result_bits", ZERO_CODE, result_bits);
        cmp_bit("reset accuracy_ok", 1'b1, accuracy_ok);
        // outputs enabled first
        // Outputs enabled before first sample, coding modes in turn
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk);
            {msb_invert_pin, low_bits_invert_pin, pattern_sel_n} <= 3'(c);
            drive(25);
            $display("Coding mode %0d done", c);
        end
        // float held, not toggled
        // Float held for a span, not toggled per sample
        @(posedge clk);
        float_pin <= 1'b1;
        drive(6);
        #1;
        cmp_bit("result_oe", 1'b0, result_oe);
        cmp_bit("flags_oe", 1'b0, flags_oe);
        @(posedge clk);
        float_pin <= 1'b0;
        #1;
        cmp_bit("result_oe", 1'b1, result_oe);
        cmp_bit("flags_oe", 1'b1, flags_oe);
        $display("Float test done");
        // Standby with stopped sample clock, then wake
        @(posedge clk);
        sample_en <= 1'b0;
        sleep_request_pin <= 1'b1;
        repeat (19) @(posedge clk);
        #1;
        cmp_bit("asleep", 1'b0, asleep);
        @(posedge clk);
        #1;
        cmp_bit("asleep", 1'b1, asleep);
        @(posedge clk);
        sleep_request_pin <= 1'b0;
        sample_en <= 1'b1;
        @(posedge clk);
        #1;
        cmp_bit("asleep", 1'b0, asleep);
        k0 = kept;
        repeat (3) @(posedge clk);
        #1;
        cmp_bit("accuracy_ok", 1'b0, accuracy_ok);
        @(posedge clk);
        #1;
        cmp_bit("accuracy_ok", 1'b1, accuracy_ok);
        cmp_bit("capture held off", 1'b1, kept == k0);
        drive(10);
        cmp_bit("capture kept", 1'b1, kept > 0);
        $display("Standby test done");
        results();
    end
endmodule

// *** sim/capture_model.sv ***
// Capture model for the parallel bus on the far side of the output stage.
// Assumes it sees the same clock and sample enable as the converter.
module capture_model (
    // Clock and sample timing
    input wire logic clk,
    input wire logic sample_en,
    // Bus from the converter
    input wire logic [adc_fmt_pkg::RES_W-1:0] result_bits,
    input wire logic result_oe,
    input wire logic accuracy_ok,
    // Captured data
    output logic [adc_fmt_pkg::RES_W-1:0] last_word,
    output int kept
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Capture
    initial
    begin
        last_word = '0;
        kept = 0;
    end
    always @(posedge clk)
    begin
        if (sample_en && result_oe && accuracy_ok)
        begin
            last_word <= result_bits;
            kept <= kept + 1;
        end
    end
endmodule

// *** verilog/adc_fmt_pkg.sv ***
// Constants shared by the converter output stage.
// Assumes a single 100 MHz system clock and a sample-rate enable pulse.
package adc_fmt_pkg;
    // ==========================================================
    // Widths and field positions
    localparam int RES_W = 10;
    localparam int MSB_POS = 9;
    localparam int PIPE_DEPTH = 3;
    localparam logic [RES_W-1:0] TEST_PATTERN = 10'h2aa;
    localparam logic [RES_W-1:0] MSB_MASK = 10'h200;
    localparam logic [RES_W-1:0] LOW_MASK = 10'h1ff;
    localparam logic [RES_W-1:0] ZERO_CODE = 10'h000;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STOP_DETECT_NS = 200;
    localparam int STOP_DETECT_CYC = (STOP_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] STOP_LAST = 5'(STOP_DETECT_CYC - 1);
    localparam logic [2:0] SETTLE_SAMPLES = 3'h4;
    localparam logic [2:0] SETTLE_LAST = 3'h3;
    // ==========================================================
    // Power state
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_WAKE = 2'b10
    } pwr_state_t;
endpackage

// *** verilog/adc_output_format.sv ***
// Output formatting, range flags, float control and standby for a
// pipelined 10-bit converter core. Assumes the core presents one raw
// straight-binary code plus below/above-range decisions per sample_en.
//
// Overview of operation
// - Invert pins choose straight binary, twos complement or ones complement coding.
// - Pattern-select low replaces result with 1010101010, then inverts per pins.
// - Range flags follow input level only, never invert or pattern settings.
// - Standby high with sample clock stopped puts the block asleep.
// - After wake, accuracy is flagged only after four clocked samples.
// - Float input high releases all data outputs and both flags.
// - Under-range flag low for samples within range.
// - Under-range flag high, pipeline aligned, when input below range.
// - Over-range flag low for samples within range.
// - Over-range flag high, pipeline aligned, when input above range.
module adc_output_format (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Converter core
    input wire logic sample_en,
    input wire logic [adc_fmt_pkg::RES_W-1:0] raw_code,
    input wire logic raw_below,
    input wire logic raw_above,
    // Control pins
    input wire logic msb_invert_pin,
    input wire logic low_bits_invert_pin,
    input wire logic pattern_sel_n,
    input wire logic float_pin,
    input wire logic sleep_request_pin,
    // Output pins
    output logic [adc_fmt_pkg::RES_W-1:0] result_bits,
    output logic result_oe,
    output logic over_range_flag,
    output logic under_range_flag,
    output logic flags_oe,
    // Status
    output logic asleep,
    output logic accuracy_ok
);
    import adc_fmt_pkg::*;

    // ==========================================================
    // Pipeline
    logic [RES_W-1:0] code_r [PIPE_DEPTH];
    logic [RES_W-1:0] code_nxt [PIPE_DEPTH];
    logic [PIPE_DEPTH-1:0] below_r, below_nxt, above_r, above_nxt;
    logic [RES_W-1:0] data_r, data_nxt;
    logic under_r, under_nxt, over_r, over_nxt;
    logic [RES_W-1:0] inv_mask, src_code;

    // Coding mask from the invert pins
    always_comb
    begin
        inv_mask = ZERO_CODE;
        if (msb_invert_pin)
            inv_mask = inv_mask | MSB_MASK;
        if (low_bits_invert_pin)
            inv_mask = inv_mask | LOW_MASK;
    end

    // Shift the pipeline and format the final stage
    always_comb
    begin
        code_nxt = code_r;
        below_nxt = below_r;
        above_nxt = above_r;
        data_nxt = data_r;
        under_nxt = under_r;
        over_nxt = over_r;
        src_code = pattern_sel_n ? code_r[PIPE_DEPTH-1] : TEST_PATTERN;
        if (sample_en)
        begin
            code_nxt[0] = raw_code;
            below_nxt[0] = raw_below;
            above_nxt[0] = raw_above;
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                code_nxt[i] = code_r[i-1];
                below_nxt[i] = below_r[i-1];
                above_nxt[i] = above_r[i-1];
            end
            data_nxt = src_code ^ inv_mask;
            under_nxt = below_r[PIPE_DEPTH-1];
            over_nxt = above_r[PIPE_DEPTH-1];
        end
        if (sys_rst)
        begin
            for (int i = 0; i < PIPE_DEPTH; i++)
                code_nxt[i] = ZERO_CODE;
            below_nxt = '0;
            above_nxt = '0;
            data_nxt = ZERO_CODE;
            under_nxt = 1'b0;
            over_nxt = 1'b0;
        end
    end

    // Pipeline registers
    always_ff @(posedge clk)
    begin
        code_r <= code_nxt;
        below_r <= below_nxt;
        above_r <= above_nxt;
        data_r <= data_nxt;
        under_r <= under_nxt;
        over_r <= over_nxt;
    end

    assign result_bits = data_r;
    assign under_range_flag = under_r;
    assign over_range_flag = over_r;
    assign result_oe = ~float_pin;
    assign flags_oe = ~float_pin;

    // ==========================================================
    // Standby
    pwr_state_t state_r, state_nxt;
    logic [4:0] idle_r, idle_nxt;
    logic [2:0] settle_r, settle_nxt;

    // Stopped-clock detection and settling count
    always_comb
    begin
        state_nxt = state_r;
        idle_nxt = idle_r;
        settle_nxt = settle_r;
        case (state_r)
            PWR_RUN:
            begin
                if (sleep_request_pin && !sample_en)
                    idle_nxt = idle_r + 5'h1;
                else
                    idle_nxt = 5'h0;
                // sleep once the sample clock has stopped
                if (sleep_request_pin && !sample_en && idle_r == STOP_LAST)
                    state_nxt = PWR_SLEEP;
            end
            PWR_SLEEP:
            begin
                idle_nxt = 5'h0;
                settle_nxt = 3'h0;
                if (!sleep_request_pin && sample_en)
                    state_nxt = PWR_WAKE;
            end
            PWR_WAKE:
            begin
                if (sample_en)
                    settle_nxt = settle_r + 3'h1;
                if (sample_en && settle_r == SETTLE_LAST)
                    state_nxt = PWR_RUN;
            end
            default:
                state_nxt = PWR_RUN;
        endcase
        if (sys_rst)
        begin
            state_nxt = PWR_RUN;
            idle_nxt = 5'h0;
            settle_nxt = 3'h0;
        end
    end

    // Standby registers
    always_ff @(posedge clk)
    begin
        state_r <= state_nxt;
        idle_r <= idle_nxt;
        settle_r <= settle_nxt;
    end

    assign asleep = (state_r == PWR_SLEEP);
    assign accuracy_ok = (state_r == PWR_RUN);

    // ==========================================================
    // Checks
    sequence below_in_s;
        sample_en && raw_below ##1 sample_en [*3];
    endsequence
    sequence inrange_low_s;
        sample_en && !raw_below ##1 sample_en [*3];
    endsequence
    sequence above_in_s;
        sample_en && raw_above ##1 sample_en [*3];
    endsequence
    sequence inrange_high_s;
        sample_en && !raw_above ##1 sample_en [*3];
    endsequence

    binary_code_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_en && pattern_sel_n && !low_bits_invert_pin |=>
        result_bits == ($past(code_r[PIPE_DEPTH-1]) ^
        ($past(msb_invert_pin) ? MSB_MASK : ZERO_CODE)))
        else $error("Result coding wrong");
    test_pattern_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_en && !pattern_sel_n && !msb_invert_pin && !low_bits_invert_pin |=>
        result_bits == TEST_PATTERN)
        else $error("Test pattern wrong");
    ones_comp_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_en && msb_invert_pin && low_bits_invert_pin |=>
        result_bits == ~($past(pattern_sel_n) ? $past(code_r[PIPE_DEPTH-1]) : TEST_PATTERN))
        else $error("Ones complement wrong");
    flag_source_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_en |=> under_range_flag == $past(below_r[PIPE_DEPTH-1]) &&
        over_range_flag == $past(above_r[PIPE_DEPTH-1]))
        else $error("Range flags disturbed");
    sleep_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == PWR_RUN && sleep_request_pin && !sample_en && idle_r == STOP_LAST |=> asleep)
        else $error("Sleep not entered");
    wake_settle_a: assert property (@(posedge clk) disable iff (sys_rst)
        asleep && !sleep_request_pin && sample_en |=> !accuracy_ok [*4])
        else $error("Accuracy flagged too early");
    float_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        float_pin |-> !result_oe && !flags_oe)
        else $error("Outputs driven while floated");
    under_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        inrange_low_s |=> !under_range_flag)
        else $error("Under-range set in range");
    under_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        below_in_s |=> under_range_flag)
        else $error("Under-range missed");
    over_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        inrange_high_s |=> !over_range_flag)
        else $error("Over-range set in range");
    over_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        above_in_s |=> over_range_flag)
        else $error("Over-range missed");
endmodule
